// >>> fgr_defs.svh
// constants for the fine-granularity refresh block
`ifndef FGR_DEFS_SVH
`define FGR_DEFS_SVH

`define CLK_PERIOD_NS      40
`define BASE_INTERVAL_NS   7800
`define BASE_INTERVAL_CYC  (`BASE_INTERVAL_NS / `CLK_PERIOD_NS)
`define NS_TO_CYC(ns)      (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RFC1_2G_NS  160
`define RFC1_4G_NS  260
`define RFC1_8G_NS  350
`define RFC2_2G_NS  110
`define RFC2_4G_NS  160
`define RFC2_8G_NS  260
`define RFC4_2G_NS  90
`define RFC4_4G_NS  110
`define RFC4_8G_NS  160

`define OFS_CTRL    6'h00
`define OFS_STATUS  6'h04
`define OFS_FLAGS   6'h08

`define CTRL_MODE_LSB    0
`define CTRL_TCR_BIT     3
`define CTRL_DENS_LSB    4
`define CTRL_TEMP_LSB    6
`define CTRL_RESET       8'h10

`define MODE_FIXED_1X  3'h0
`define MODE_FIXED_2X  3'h1
`define MODE_FIXED_4X  3'h2
`define MODE_OTF_1X2X  3'h5
`define MODE_OTF_1X4X  3'h6

`define FLAG_BUSY_CMD  0
`define FLAG_RATE_CHG  1
`define FLAG_OTF_MIX   2
`define FLAG_RSVD_MODE 3
`define FLAG_TCR_MODE  4
`define FLAG_WIDTH     5

`endif

// >>> fgr_pkg.sv
// types shared by the fine-granularity refresh block
package fgr_pkg;

  typedef enum logic [1:0] {
    RATE_1X = 2'h0,
    RATE_2X = 2'h1,
    RATE_4X = 2'h2
  } rate_e;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b01,
    ST_SELF   = 2'b10
  } pwr_state_e;

  typedef struct packed {
    logic [3:0] cnt;
    logic       busy;
  } timer_s;

  typedef struct packed {
    logic [2:0]  mode;
    logic        tcr_en;
    logic [1:0]  density;
    logic [1:0]  temp_band;
    rate_e       rate;
    logic [1:0]  sub_cnt;
    logic        sr_need;
    logic        extra_need;
    logic [2:0]  extra_cnt;
    pwr_state_e  pwr;
    logic [4:0]  flags;
    logic [7:0]  interval;
    logic [3:0]  cycle_time;
    logic        waitreq;
    logic [31:0] rdata;
  } fgr_state_s;

endpackage

// >>> refresh_busy_timer.sv
// refresh cycle-time timer: busy for load_val cycles after a load
`timescale 1ns/100ps
module refresh_busy_timer
  import fgr_pkg::*;
(
  input  wire logic       mclk,      // clock
  input  wire logic       rst_b,     // sync reset, active low
  input  wire logic       load,      // start a refresh cycle
  input  wire logic [3:0] load_val,  // cycle time in clocks
  output logic            busy       // refresh in progress
);

  timer_s st_reg;
  timer_s st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.cnt = load_val;
    end else if (st_reg.cnt != 4'h0) begin
      st_next.cnt = st_reg.cnt - 4'h1;
    end
    st_next.busy = (st_next.cnt != 4'h0);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.busy;

  chk_timer_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    load && load_val == 4'h3 |=> busy [*3] ##1 !busy)
    else $error("refresh timer did not hold busy for its load value");

endmodule // refresh_busy_timer

// >>> fgr_refresh_ctrl.sv
// fine-granularity refresh rate control with avalon register slave
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`include "fgr_defs.svh"
`timescale 1ns/100ps
module fgr_refresh_ctrl
  import fgr_pkg::*;
#(
  parameter int BASE_CYC = `BASE_INTERVAL_CYC
)(
  input  wire logic        mclk,                 // 25 MHz clock
  input  wire logic        rst_b,                // sync reset, active low
  input  wire logic [5:0]  address,              // avalon byte address
  input  wire logic        read,                 // avalon read
  input  wire logic        write,                // avalon write
  input  wire logic [31:0] writedata,            // avalon write data
  input  wire logic [3:0]  byteenable,           // avalon byte lanes
  output logic [31:0]      readdata,             // avalon read data
  output logic             waitrequest,          // avalon wait
  input  wire logic        ref_cmd,              // refresh command pulse
  input  wire logic        bank_group_bit_zero,  // sampled with refresh
  input  wire logic        other_cmd,            // any non-deselect command
  input  wire logic        sr_entry,             // self refresh entry pulse
  input  wire logic        sr_exit,              // self refresh exit pulse
  output logic             refresh_busy,         // cycle time running
  output logic [7:0]       avg_refresh_interval, // interval in clocks
  output logic [3:0]       refresh_cycle_time,   // cycle time in clocks
  output logic             extra_refresh_needed  // post-exit extras owed
);

  fgr_state_s st_reg;
  fgr_state_s st_next;
  logic       timer_busy;
  logic       ref_ok;
  logic       take;
  logic       wr_ctrl;
  rate_e      cmd_rate;
  logic [3:0] cmd_cyc;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic rate_e mode_rate(input logic [2:0] m);
    unique case (m)
      `MODE_FIXED_2X, `MODE_OTF_1X2X: mode_rate = RATE_2X;
      `MODE_FIXED_4X, `MODE_OTF_1X4X: mode_rate = RATE_4X;
      default:                        mode_rate = RATE_1X;
    endcase
  endfunction

  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = (m == `MODE_FIXED_1X) || (m == `MODE_FIXED_2X) ||
                 (m == `MODE_FIXED_4X) || (m == `MODE_OTF_1X2X) ||
                 (m == `MODE_OTF_1X4X);
  endfunction

  function automatic logic aligned(input rate_e r, input logic [1:0] c);
    aligned = (r == RATE_4X) ? (c == 2'h0) : (r == RATE_2X) ? !c[0] : 1'b1;
  endfunction

  function automatic logic [3:0] rfc_cyc(input rate_e r, input logic [1:0] d);
    int ns;
    ns = `RFC1_8G_NS;
    unique case ({r, d})
      {RATE_1X, 2'h0}: ns = `RFC1_2G_NS;
      {RATE_1X, 2'h1}: ns = `RFC1_4G_NS;
      {RATE_2X, 2'h0}: ns = `RFC2_2G_NS;
      {RATE_2X, 2'h1}: ns = `RFC2_4G_NS;
      {RATE_2X, 2'h2}: ns = `RFC2_8G_NS;
      {RATE_4X, 2'h0}: ns = `RFC4_2G_NS;
      {RATE_4X, 2'h1}: ns = `RFC4_4G_NS;
      {RATE_4X, 2'h2}: ns = `RFC4_8G_NS;
      default:         ns = `RFC1_8G_NS;
    endcase
    rfc_cyc = 4'(`NS_TO_CYC(ns));
  endfunction

  // base interval shifted by rate and temperature band
  function automatic logic [7:0] refi_cyc(input rate_e r, input logic [1:0] t);
    logic [7:0] b;
    b = 8'(BASE_CYC);
    refi_cyc = b >> ({1'b0, r} + {1'b0, t});
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // command decode

  assign take    = (read || write) && !st_reg.waitreq;
  assign wr_ctrl = write && take && (address == `OFS_CTRL) && byteenable[0];
  assign ref_ok  = ref_cmd && !timer_busy && (st_reg.pwr == ST_ACTIVE);

  always_comb begin
    cmd_rate = mode_rate(st_reg.mode);
    if (st_reg.mode[2] && !bank_group_bit_zero) begin
      cmd_rate = RATE_1X;
    end
  end

  assign cmd_cyc = rfc_cyc(cmd_rate, st_reg.density);

  refresh_busy_timer u_timer (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .load     (ref_ok),
    .load_val (cmd_cyc),
    .busy     (timer_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [2:0] new_mode;
    logic [7:0] wb;
    logic [4:0] set;
    new_mode = writedata[`CTRL_MODE_LSB +: 3];
    wb       = writedata[7:0];
    set      = '0;
    st_next  = st_reg;

    // register bus: one wait cycle, then answer
    st_next.waitreq = !((read || write) && st_reg.waitreq);
    if ((read || write) && st_reg.waitreq) begin
      unique case (address)
        `OFS_CTRL:   st_next.rdata = {24'h0, st_reg.temp_band, st_reg.density,
                                      st_reg.tcr_en, st_reg.mode};
        `OFS_STATUS: st_next.rdata = {12'h0, st_reg.cycle_time, st_reg.interval, 1'b0,
                                      st_reg.pwr == ST_SELF, st_reg.extra_need,
                                      st_reg.sub_cnt, st_reg.rate, timer_busy};
        `OFS_FLAGS:  st_next.rdata = {27'h0, st_reg.flags};
        default:     st_next.rdata = 32'h0;
      endcase
    end

    if (wr_ctrl) begin
      st_next.tcr_en    = wb[`CTRL_TCR_BIT];
      st_next.density   = wb[`CTRL_DENS_LSB +: 2];
      st_next.temp_band = wb[`CTRL_TEMP_LSB +: 2];
      if (!mode_legal(new_mode)) begin
        set[`FLAG_RSVD_MODE] = 1'b1;
      end else begin
        st_next.mode = new_mode;
        if (mode_rate(new_mode) != mode_rate(st_reg.mode)) begin
          if (!aligned(mode_rate(st_reg.mode), st_reg.sub_cnt)) begin
            set[`FLAG_RATE_CHG] = 1'b1;
          end
          st_next.sub_cnt = 2'h0;
          st_next.rate    = mode_rate(new_mode);
        end else if (!new_mode[2]) begin
          st_next.rate = mode_rate(new_mode);
        end
      end
      if (wb[`CTRL_TCR_BIT] && mode_legal(new_mode) && new_mode != `MODE_FIXED_1X) begin
        set[`FLAG_TCR_MODE] = 1'b1;
      end
    end

    if ((ref_cmd || other_cmd) && timer_busy) begin
      set[`FLAG_BUSY_CMD] = 1'b1;
    end

    if (ref_ok) begin
      st_next.rate = cmd_rate;
      if (cmd_rate == RATE_1X) begin
        if (st_reg.mode[2] && !aligned(mode_rate(st_reg.mode), st_reg.sub_cnt)) begin
          set[`FLAG_OTF_MIX] = 1'b1;
        end
        st_next.sub_cnt = 2'h0;
      end else begin
        st_next.sub_cnt = st_reg.sub_cnt + 2'h1;
      end
      if (st_reg.extra_need) begin
        st_next.extra_cnt = st_reg.extra_cnt + 3'h1;
        if (cmd_rate == RATE_1X ||
            (cmd_rate == RATE_2X && st_reg.extra_cnt == 3'h1) ||
            (cmd_rate == RATE_4X && st_reg.extra_cnt == 3'h3)) begin
          st_next.extra_need = 1'b0;
          st_next.extra_cnt  = 3'h0;
          st_next.sub_cnt    = 2'h0;
        end
      end
    end

    unique case (st_reg.pwr)
      ST_ACTIVE: if (sr_entry && !timer_busy) begin
        st_next.pwr     = ST_SELF;
        st_next.sr_need = !aligned(st_reg.rate, st_reg.sub_cnt);
      end
      ST_SELF: if (sr_exit) begin
        st_next.pwr        = ST_ACTIVE;
        st_next.extra_need = st_reg.sr_need;
        st_next.extra_cnt  = 3'h0;
        st_next.sub_cnt    = 2'h0;
      end
      default: st_next.pwr = ST_ACTIVE;
    endcase

    // write one to clear; a new event wins
    if (write && take && address == `OFS_FLAGS && byteenable[0]) begin
      st_next.flags = st_reg.flags & ~writedata[`FLAG_WIDTH-1:0];
    end
    st_next.flags = st_next.flags | set;

    st_next.interval   = refi_cyc(st_next.rate, st_next.temp_band);
    st_next.cycle_time = rfc_cyc(st_next.rate, st_next.density);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg            <= '0;
      st_reg.mode       <= `MODE_FIXED_1X;
      st_reg.density    <= 2'(`CTRL_RESET >> `CTRL_DENS_LSB);
      st_reg.rate       <= RATE_1X;
      st_reg.pwr        <= ST_ACTIVE;
      st_reg.waitreq    <= 1'b1;
      st_reg.interval   <= 8'(BASE_CYC);
      st_reg.cycle_time <= 4'(`NS_TO_CYC(`RFC1_4G_NS));
    end else begin
      st_reg <= st_next;
    end
  end

  assign readdata             = st_reg.rdata;
  assign waitrequest          = st_reg.waitreq;
  assign refresh_busy         = timer_busy;
  assign avg_refresh_interval = st_reg.interval;
  assign refresh_cycle_time   = st_reg.cycle_time;
  assign extra_refresh_needed = st_reg.extra_need;

  ////////////////////////////////////////////////////////////////////////
  // checks

  chk_reset_fixed1x: assert property (@(posedge mclk)
    $rose(rst_b) |-> st_reg.mode == `MODE_FIXED_1X && avg_refresh_interval == 8'(BASE_CYC))
    else $error("reset did not leave fixed 1x at base interval");

  chk_busy_single: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_ok && cmd_rate == RATE_1X && st_reg.density == 2'h0 |=>
      refresh_busy [*4] ##1 !refresh_busy)
    else $error("single-rate cycle time wrong for smallest density");

  chk_busy_quad: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_ok && cmd_rate == RATE_4X && st_reg.density == 2'h2 |=>
      refresh_busy [*4] ##1 !refresh_busy)
    else $error("quad-rate cycle time wrong for largest density");

  chk_rate_apply: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_ok |=> avg_refresh_interval == (8'(BASE_CYC) >> ({1'b0, $past(cmd_rate)} +
                                         {1'b0, st_reg.temp_band})))
    else $error("interval did not follow the refresh rate");

  chk_otf_select: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_ok && st_reg.mode == `MODE_OTF_1X2X |=>
      st_reg.rate == ($past(bank_group_bit_zero) ? RATE_2X : RATE_1X))
    else $error("on-the-fly refresh picked wrong rate");

  chk_same_rate: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl && mode_legal(writedata[2:0]) &&
    mode_rate(writedata[2:0]) == mode_rate(st_reg.mode) |=> !$rose(st_reg.flags[`FLAG_RATE_CHG]))
    else $error("same-rate mode switch counted as rate change");

  chk_sr_accept: assert property (@(posedge mclk) disable iff (!rst_b)
    st_reg.pwr == ST_ACTIVE && sr_entry && !timer_busy |=> st_reg.pwr == ST_SELF)
    else $error("self refresh entry refused");

  chk_rsvd_mode: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl && !mode_legal(writedata[2:0]) |=> $stable(st_reg.mode) && st_reg.flags[3])
    else $error("reserved mode code accepted");

  chk_bus_answer: assert property (@(posedge mclk) disable iff (!rst_b)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer not after one wait cycle");

  chk_busy_double: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_ok && cmd_rate == RATE_2X && st_reg.density == 2'h2 |=>
      refresh_busy [*7] ##1 !refresh_busy)
    else $error("double-rate cycle time wrong for largest density");

  chk_otf_quad_pick: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_ok && st_reg.mode == `MODE_OTF_1X4X |=>
      st_reg.rate == ($past(bank_group_bit_zero) ? RATE_4X : RATE_1X))
    else $error("on-the-fly quad refresh picked wrong rate");

  chk_busy_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    (ref_cmd || other_cmd) && refresh_busy |=> st_reg.flags[`FLAG_BUSY_CMD])
    else $error("command during refresh cycle not flagged");

  chk_fixed_rate: assert property (@(posedge mclk) disable iff (!rst_b)
    ref_ok && !st_reg.mode[2] |=> st_reg.rate == mode_rate($past(st_reg.mode)))
    else $error("fixed-mode refresh ran at the wrong rate");

  chk_same_rate_cnt: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl && mode_legal(writedata[2:0]) && !ref_ok && st_reg.pwr == ST_ACTIVE &&
    mode_rate(writedata[2:0]) == mode_rate(st_reg.mode) |=> $stable(st_reg.sub_cnt))
    else $error("same-rate mode switch reset the sub-rate count");

  chk_tcr_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_ctrl && writedata[`CTRL_TCR_BIT] && mode_legal(writedata[2:0]) &&
    writedata[2:0] != `MODE_FIXED_1X |=> st_reg.flags[`FLAG_TCR_MODE])
    else $error("temperature-controlled refresh with sub-rate mode not flagged");

  cov_otf_quad: cover property (@(posedge mclk) disable iff (!rst_b)
    ref_ok && st_reg.mode == `MODE_OTF_1X4X && cmd_rate == RATE_4X);
  cov_extra: cover property (@(posedge mclk) disable iff (!rst_b)
    $fell(extra_refresh_needed));
  cov_rate_flag: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(st_reg.flags[`FLAG_RATE_CHG]));
  cov_self_refresh: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(st_reg.pwr == ST_SELF));
  cov_busy_cmd: cover property (@(posedge mclk) disable iff (!rst_b)
    $rose(st_reg.flags[`FLAG_BUSY_CMD]));

endmodule // fgr_refresh_ctrl

// >>> ref_issue_model.sv
// controller-side model that issues refresh and self refresh commands
`timescale 1ns/100ps
module ref_issue_model (
  input  wire logic mclk,                // 25 MHz clock
  input  wire logic refresh_busy,        // cycle time running
  output logic      ref_cmd,             // refresh pulse
  output logic      bank_group_bit_zero, // sub-rate select on the fly
  output logic      other_cmd,           // non-deselect command
  output logic      sr_entry,            // self refresh entry pulse
  output logic      sr_exit,             // self refresh exit pulse
  output logic      timed_out            // a wait ran out
);
  logic [1:0] sub_count;  // sub-rate refreshes modulo four

  initial begin
    {ref_cmd, bank_group_bit_zero, other_cmd, sr_entry, sr_exit, timed_out} = 6'h00;
    sub_count = 2'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (refresh_busy !== 1'b0 && n < 100);  // nothing inside the cycle time
    if (n >= 100) timed_out = 1'b1;
  endtask

  // early holds the refresh and a second command into the busy time
  task automatic refresh(input logic sub, input logic early, output int len);
    wait_idle();
    @(posedge mclk);
    ref_cmd             <= 1'b1;
    bank_group_bit_zero <= sub;
    @(posedge mclk);
    ref_cmd             <= early;
    other_cmd           <= early;
    bank_group_bit_zero <= ~sub;
    sub_count           <= sub ? sub_count + 2'h1 : 2'h0;
    @(negedge mclk);
    len = int'(refresh_busy === 1'b1);
    @(posedge mclk);
    ref_cmd   <= 1'b0;
    other_cmd <= 1'b0;
    @(negedge mclk);
    while (refresh_busy === 1'b1 && len < 100) begin
      len++;
      @(negedge mclk);
    end
  endtask

  task automatic self_refresh();
    wait_idle();
    @(posedge mclk);
    sr_entry <= 1'b1;  // entry whatever the count
    @(posedge mclk);
    sr_entry <= 1'b0;
    repeat (4) @(posedge mclk);
    sr_exit   <= 1'b1;
    sub_count <= 2'h0;
    @(posedge mclk);
    sr_exit <= 1'b0;
  endtask

  // n of 1 pays with one single-rate refresh, else n sub-rate refreshes
  task automatic pay_extras(input int n);
    int len;
    for (int i = 0; i < n; i++) refresh(n != 1, 1'b0, len);
  endtask
endmodule // ref_issue_model

// >>> testbench.sv
// self-checking bench for the fine-granularity refresh block
`timescale 1ns/100ps
module testbench;
  import fgr_pkg::*;
  localparam int base_cyc = 195;
  logic        mclk;
  logic        rst_b;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        ref_cmd, bank_group_bit_zero, other_cmd, sr_entry, sr_exit, timed_out;
  logic        refresh_busy;
  logic [7:0]  avg_refresh_interval;
  logic [3:0]  refresh_cycle_time;
  logic        extra_refresh_needed;
  logic [31:0] d;
  int          failures, tests_run, len;
  int          sr_tab [4][4] = '{'{8'h16, 3, 1, 4}, '{8'h15, 1, 1, 1}, '{8'h15, 2, 0, 0},
                                 '{8'h11, 1, 1, 2}};

  fgr_refresh_ctrl #(.BASE_CYC(base_cyc)) fgr_refresh_ctrl_inst (.mclk(mclk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .ref_cmd(ref_cmd), .bank_group_bit_zero(bank_group_bit_zero), .other_cmd(other_cmd),
    .sr_entry(sr_entry), .sr_exit(sr_exit), .refresh_busy(refresh_busy),
    .avg_refresh_interval(avg_refresh_interval), .refresh_cycle_time(refresh_cycle_time),
    .extra_refresh_needed(extra_refresh_needed));
  ref_issue_model ref_issue_model_inst (.mclk(mclk), .refresh_busy(refresh_busy),
    .ref_cmd(ref_cmd), .bank_group_bit_zero(bank_group_bit_zero), .other_cmd(other_cmd),
    .sr_entry(sr_entry), .sr_exit(sr_exit), .timed_out(timed_out));

  //////////////////////////////////////////////////////////////////////////////
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (timed_out === 1'b1) begin
    failures++;
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    print_verdict();
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    address   <= a;
    write     <= wr;
    read      <= ~wr;
    writedata <= wd;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    d     = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask

  task automatic check_flags(input logic [31:0] exp);
    bus(6'h08, 1'b0, 32'h0);
    check("flags", exp, d);
    bus(6'h08, 1'b1, 32'h0000001f);
  endtask

  function automatic int cyc(input int r, input int dn);
    int ns [3][3] = '{'{160, 260, 350}, '{110, 160, 260}, '{90, 110, 160}};
    return (ns[r][dn] + 39) / 40;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {address, read, write, writedata, failures, tests_run} = '0;
    rst_b      = 1'b0;
    byteenable = 4'hf;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    settle();
    check("interval", base_cyc, avg_refresh_interval);
    check("cycle time", cyc(0, 1), refresh_cycle_time);
    bus(6'h00, 1'b0, 32'h0);
    check("ctrl", 32'h00000010, d);
    bus(6'h0c, 1'b0, 32'h0);
    check("unmapped", 32'h0, d);
    $display("test reset done");
    for (int m = 0; m < 3; m++) for (int dn = 0; dn < 3; dn++) begin
      bus(6'h00, 1'b1, {24'h0, 2'((m + dn) % 4), dn[1:0], 1'b0, m[2:0]});
      settle();
      check("interval", base_cyc >> (m + (m + dn) % 4), avg_refresh_interval);
      check("cycle time", cyc(m, dn), refresh_cycle_time);
      repeat (1 << m) begin
        ref_issue_model_inst.refresh(m != 0, 1'b0, len);
        check("busy length", cyc(m, dn), len);
      end
    end
    check_flags(32'h0);
    $display("test fixed modes done");
    for (int k = 1; k < 3; k++) begin
      bus(6'h00, 1'b1, 32'h10 + k);
      repeat (k) ref_issue_model_inst.refresh(1'b1, 1'b0, len);
      bus(6'h00, 1'b1, 32'h00000010);
      check_flags(32'h00000002);
    end
    bus(6'h00, 1'b1, 32'h00000011);
    ref_issue_model_inst.refresh(1'b1, 1'b0, len);
    bus(6'h00, 1'b1, 32'h00000015);
    check_flags(32'h0);
    bus(6'h00, 1'b1, 32'h00000010);
    check_flags(32'h00000002);
    $display("test rate change done");
    foreach (sr_tab[i]) begin
      bus(6'h00, 1'b1, 32'h10 + {29'h0, 3'(i < 2 ? i + 3 : 7)});
      bus(6'h00, 1'b0, 32'h0);
      check("ctrl", 32'h00000010, d);
      check_flags(32'h00000008);
    end
    byteenable <= 4'he;
    bus(6'h00, 1'b1, 32'h00000011);
    byteenable <= 4'hf;
    bus(6'h00, 1'b0, 32'h0);
    check("ctrl", 32'h00000010, d);
    bus(6'h00, 1'b1, 32'h00000019);
    check_flags(32'h00000010);
    $display("test reserved and tcr done");
    bus(6'h00, 1'b1, 32'h00000015);
    ref_issue_model_inst.refresh(1'b0, 1'b0, len);
    check("busy length", cyc(0, 1), len);
    check("interval", base_cyc, avg_refresh_interval);
    ref_issue_model_inst.refresh(1'b1, 1'b0, len);
    check("busy length", cyc(1, 1), len);
    bus(6'h04, 1'b0, 32'h0);
    check("status", {12'h000, 4'(cyc(1, 1)), 8'(base_cyc >> 1), 8'h0a}, d);
    ref_issue_model_inst.refresh(1'b0, 1'b0, len);
    check_flags(32'h00000004);
    bus(6'h00, 1'b1, 32'h00000016);
    ref_issue_model_inst.refresh(1'b1, 1'b0, len);
    check("busy length", cyc(2, 1), len);
    ref_issue_model_inst.refresh(1'b0, 1'b0, len);
    check_flags(32'h00000004);
    bus(6'h00, 1'b1, 32'h00000010);
    ref_issue_model_inst.refresh(1'b0, 1'b1, len);
    check("busy length", cyc(0, 1), len);
    check_flags(32'h00000001);
    $display("test on the fly and busy done");
    foreach (sr_tab[i]) begin
      bus(6'h00, 1'b1, sr_tab[i][0]);
      repeat (sr_tab[i][1]) ref_issue_model_inst.refresh(1'b1, 1'b0, len);
      bus(6'h04, 1'b0, 32'h0);
      check("sub count", {30'h0, ref_issue_model_inst.sub_count}, {30'h0, d[4:3]});
      ref_issue_model_inst.self_refresh();
      settle();
      check("extra needed", sr_tab[i][2], extra_refresh_needed);
      ref_issue_model_inst.pay_extras(sr_tab[i][3]);
      settle();
      check("extra paid", 32'h0, extra_refresh_needed);
    end
    $display("test self refresh done");
    print_verdict();
  end
endmodule // testbench
